//--- rtl/smp_pkg.sv
// Purpose: shared constants and carriers of the serial memory programming port
// Assumes: 40 MHz core clock, programmer follows the four-byte frame protocol
// Notes:   Operation list below
//
// Operation
// - programming works while the reset pin is held low or the power-on enable strap was low
// - after reset goes low, only Programming Enable is honoured first
// - data in and out use alternate port pins; clock pin is shared
// - serial EEPROM write erases the location itself before writing
// - chip erase sets every Flash and EEPROM byte to all ones
// - incoming bits are sampled on serial clock rising edge
// - outgoing bits change on serial clock falling edge
// - enable pin low at power-on also enters mode until power-down
// - second enable byte is echoed while the third byte shifts in
// - page buffer loads one byte per instruction, low byte before high
// - Write Page with nine high address bits commits buffered page
// - EEPROM written one byte per instruction; programmer waits byte time
// - read instruction returns addressed location on serial output
// - reset pin high ends a session entered by the reset pin and resumes normal operation
// - Programming Enable is bytes ac, 53 then two free bytes
// - chip erase is byte ac then a byte starting 100
// - reads inside a page being programmed return all ones until done
package smp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int FLASH_WAIT_US = 4500;
  localparam int EE_WAIT_US    = 9000;
  localparam int ERASE_WAIT_US = 9000;
  localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int EE_WAIT_CYC    = EE_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int BUSY_W         = 20;

  // ----------------------------------------------------------------
  // frame layout and instruction codes
  // ----------------------------------------------------------------
  localparam logic [5:0] FRAME_BITS = 6'h20;
  localparam logic [5:0] RD_SLOT    = 6'h18;
  localparam logic [7:0] B1_SPECIAL = 8'hac;
  localparam logic [7:0] B2_ENABLE  = 8'h53;
  localparam logic [2:0] B2_ERASE   = 3'h4;
  localparam logic [3:0] B1_RD_FL   = 4'h2;
  localparam logic [3:0] B1_LD_PG   = 4'h4;
  localparam logic [7:0] B1_WR_PG   = 8'h4c;
  localparam logic [7:0] B1_RD_EE   = 8'ha0;
  localparam logic [7:0] B1_WR_EE   = 8'hc0;
  localparam int         H_BIT      = 3;
  localparam logic [7:0] ERASED     = 8'hff;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int PG_WORD_W = 7;
  localparam int PG_NUM_W  = 9;
  localparam int EE_ADR_W  = 12;
  localparam int ADR_W     = 16;

  typedef enum logic [1:0] {OP_FLASH_WR, OP_EE_WR, OP_ERASE} smp_op_t;
  typedef enum logic {SP_FLASH, SP_EE} smp_space_t;

  // write request toward the array controller
  typedef struct packed {
    smp_op_t          op;
    logic             hi;
    logic [ADR_W-1:0] addr;
    logic [7:0]       data;
  } smp_req_t;

  // read address toward the arrays
  typedef struct packed {
    smp_space_t       space;
    logic             hi;
    logic [ADR_W-1:0] addr;
  } smp_rd_t;

endpackage : smp_pkg

//--- rtl/smp_fifo2.sv
// Purpose: small buffer between command source and array controller
// Assumes: single clock, source and sink on the same clock
// Notes:   full and empty are exact; in_ready drops when every slot is used
`timescale 1ns/1ps
module smp_fifo2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } smp_fifo_st_t;

  smp_fifo_st_t st_q, st_d;
  logic         push;
  logic         pop;

  assign in_ready  = st_q.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_q.cnt != '0;
  assign out_data  = st_q.mem[st_q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointers wrap at DEPTH so any depth of two or more works
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = in_data;
      st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : smp_fifo2

//--- rtl/smp_port.sv
// Purpose: serial programming port: frame shifter, decoder, page buffer
// Assumes: serial clock slow enough to be edge-sampled by CLOCK
// Notes:   write requests leave through a two-entry buffer with back-pressure
`timescale 1ns/1ps
module smp_port #(
  parameter int FLASH_WAIT = smp_pkg::FLASH_WAIT_CYC,
  parameter int EE_WAIT    = smp_pkg::EE_WAIT_CYC,
  parameter int ERASE_WAIT = smp_pkg::ERASE_WAIT_CYC
) (
  input  wire logic              CLOCK,
  input  wire logic              RESETN,
  input  wire logic              RESET_PIN_N,
  input  wire logic              PROG_ENABLE_PIN_N,
  input  wire logic              SHARED_CLOCK_PORT_BIT,
  input  wire logic              ALT_DATA_IN_PORT_BIT,
  output logic                   ALT_DATA_OUT_PORT_BIT,
  output logic                   ALT_DATA_OUT_OE_N,
  output logic                   PROG_MODE,
  output logic                   PROG_ENABLED,
  output logic                   WRITE_BUSY,
  output smp_pkg::smp_rd_t       MEM_RD,
  input  wire logic [7:0]        MEM_RD_DATA,
  output smp_pkg::smp_req_t      MEM_REQ,
  output logic                   MEM_REQ_VALID,
  input  wire logic              MEM_REQ_READY
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {BZ_NONE, BZ_FLASH, BZ_EE, BZ_ERASE} smp_busy_t;

  typedef struct packed {
    logic [1:0]                    sck_s;
    logic [1:0]                    din_s;
    logic [1:0]                    rst_s;
    logic [1:0]                    pen_s;
    logic                          sck_prev;
    logic [1:0]                    por_cnt;
    logic                          por_done;
    logic                          pen_mode;
    logic                          enabled;
    logic [5:0]                    bit_cnt;
    logic [31:0]                   in_sr;
    logic [7:0]                    out_sr;
    logic [7:0]                    nxt_byte;
    logic                          rd_pend;
    smp_pkg::smp_rd_t              rd;
    logic [255:0][7:0]             pg;
    logic                          fl_active;
    logic [7:0]                    fl_idx;
    logic [smp_pkg::PG_NUM_W-1:0]  fl_page;
    logic                          one_valid;
    smp_pkg::smp_req_t             one_req;
    logic [smp_pkg::BUSY_W-1:0]    busy_cnt;
    smp_busy_t                     busy_kind;
    logic [smp_pkg::PG_NUM_W-1:0]  busy_page;
    logic [smp_pkg::ADR_W-1:0]     busy_ee;
  } smp_st_t;

  smp_st_t           st_q;
  smp_st_t           st_d;
  logic              prog_mode;
  logic              rise;
  logic              fall;
  logic [5:0]        cnt_n;
  logic [31:0]       sh;
  logic              busy_any;
  logic              poll_blank;
  logic              buf_in_valid;
  logic              buf_in_ready;
  smp_pkg::smp_req_t buf_in_data;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // true when b1 matches a code whose H bit is free
  function automatic logic h_match(input logic [7:0] b1, input logic [3:0] hi);
    h_match = (b1[7:4] == hi) && (b1[2:0] == 3'h0);
  endfunction : h_match

  // reads of a location still being programmed return all ones; a flush stalled
  // past its timer still counts, so polling never sees a half-written page
  always_comb begin
    poll_blank = 1'b0;
    if (busy_any) begin
      if (st_q.busy_kind == BZ_ERASE) begin
        poll_blank = 1'b1;
      end else if (st_q.busy_kind == BZ_FLASH && st_q.rd.space == smp_pkg::SP_FLASH) begin
        poll_blank = st_q.rd.addr[smp_pkg::ADR_W-1:smp_pkg::PG_WORD_W] == st_q.busy_page;
      end else if (st_q.busy_kind == BZ_EE && st_q.rd.space == smp_pkg::SP_EE) begin
        poll_blank = st_q.rd.addr == st_q.busy_ee;
      end
    end
  end

  // ----------------------------------------------------------------
  // link sampling
  // ----------------------------------------------------------------
  // mode holds while reset pin is low or the power-on enable strap was low
  assign prog_mode = ~st_q.rst_s[1] | st_q.pen_mode;
  assign rise      = st_q.sck_s[1] & ~st_q.sck_prev;
  assign fall      = ~st_q.sck_s[1] & st_q.sck_prev;
  assign cnt_n     = st_q.bit_cnt + 6'h01;
  assign sh        = {st_q.in_sr[30:0], st_q.din_s[1]};
  // requests still queued toward the array keep the port busy
  assign busy_any  = (st_q.busy_cnt != '0) | st_q.fl_active | st_q.one_valid | MEM_REQ_VALID;

  // ----------------------------------------------------------------
  // request toward the buffer
  // ----------------------------------------------------------------
  // page flush has priority; a single request never coexists with it
  always_comb begin
    buf_in_valid = st_q.fl_active | st_q.one_valid;
    buf_in_data  = st_q.one_req;
    if (st_q.fl_active) begin
      buf_in_data.op   = smp_pkg::OP_FLASH_WR;
      buf_in_data.hi   = st_q.fl_idx[0];
      buf_in_data.addr = {st_q.fl_page, st_q.fl_idx[7:1]};
      buf_in_data.data = st_q.pg[st_q.fl_idx];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // two-stage synchronisers for every pin
    st_d.sck_s    = {st_q.sck_s[0], SHARED_CLOCK_PORT_BIT};
    st_d.din_s    = {st_q.din_s[0], ALT_DATA_IN_PORT_BIT};
    st_d.rst_s    = {st_q.rst_s[0], RESET_PIN_N};
    st_d.pen_s    = {st_q.pen_s[0], PROG_ENABLE_PIN_N};
    st_d.sck_prev = st_q.sck_s[1];

    // strap catch once synchronisers have filled after power-on
    if (!st_q.por_done) begin
      st_d.por_cnt = st_q.por_cnt + 2'h1;
      if (st_q.por_cnt == 2'h3) begin
        st_d.por_done = 1'b1;
        st_d.pen_mode = ~st_q.pen_s[1];
      end
    end

    // self-timed write timer
    if (st_q.busy_cnt != '0) begin
      st_d.busy_cnt = st_q.busy_cnt - 1'b1;
    end

    // drain pending writes into the buffer
    if (buf_in_valid && buf_in_ready) begin
      if (st_q.fl_active) begin
        st_d.fl_idx = st_q.fl_idx + 8'h01;
        if (st_q.fl_idx == 8'hff) begin
          st_d.fl_active = 1'b0;
        end
      end else begin
        st_d.one_valid = 1'b0;
      end
    end

    // read data captured one cycle after the address went out
    if (st_q.rd_pend) begin
      st_d.rd_pend  = 1'b0;
      st_d.nxt_byte = poll_blank ? smp_pkg::ERASED : MEM_RD_DATA;
    end

    if (!prog_mode) begin
      // leaving the mode drops enable and realigns the frame
      st_d.enabled  = 1'b0;
      st_d.bit_cnt  = '0;
      st_d.out_sr   = '0;
      st_d.nxt_byte = '0;
      st_d.rd_pend  = 1'b0;
    end else begin
      if (fall) begin
        // byte boundary loads the next byte, otherwise shift
        if (st_q.bit_cnt[2:0] == 3'h0) begin
          st_d.out_sr = st_q.nxt_byte;
        end else begin
          st_d.out_sr = {st_q.out_sr[6:0], 1'b0};
        end
      end

      if (rise) begin
        st_d.in_sr   = sh;
        st_d.bit_cnt = cnt_n;
        if (cnt_n == 6'h08 || cnt_n == 6'h10) begin
          st_d.nxt_byte = sh[7:0];
        end else if (cnt_n == smp_pkg::RD_SLOT) begin
          st_d.nxt_byte = sh[7:0];
          if (st_q.enabled && h_match(sh[23:16], smp_pkg::B1_RD_FL)) begin
            st_d.rd.space = smp_pkg::SP_FLASH;
            st_d.rd.hi    = sh[16+smp_pkg::H_BIT];
            st_d.rd.addr  = sh[15:0];
            st_d.rd_pend  = 1'b1;
          end else if (st_q.enabled && sh[23:16] == smp_pkg::B1_RD_EE) begin
            st_d.rd.space = smp_pkg::SP_EE;
            st_d.rd.hi    = 1'b0;
            st_d.rd.addr  = {4'h0, sh[11:0]};
            st_d.rd_pend  = 1'b1;
          end
        end else if (cnt_n == smp_pkg::FRAME_BITS) begin
          st_d.bit_cnt  = '0;
          st_d.nxt_byte = '0;
          if (!st_q.enabled) begin
            // nothing but the enable code is honoured at first
            if (sh[31:24] == smp_pkg::B1_SPECIAL && sh[23:16] == smp_pkg::B2_ENABLE) begin
              st_d.enabled = 1'b1;
            end
          end else if (!busy_any) begin
            // non-read instructions during a write are dropped
            if (sh[31:24] == smp_pkg::B1_SPECIAL && sh[23:21] == smp_pkg::B2_ERASE) begin
              st_d.one_valid     = 1'b1;
              st_d.one_req.op    = smp_pkg::OP_ERASE;
              st_d.one_req.hi    = 1'b0;
              st_d.one_req.addr  = '0;
              st_d.one_req.data  = smp_pkg::ERASED;
              st_d.pg            = '1;
              st_d.busy_kind     = BZ_ERASE;
              st_d.busy_cnt      = smp_pkg::BUSY_W'(ERASE_WAIT);
            end else if (h_match(sh[31:24], smp_pkg::B1_LD_PG)) begin
              // low and high bytes sit side by side per word
              st_d.pg[{sh[14:8], sh[24+smp_pkg::H_BIT]}] = sh[7:0];
            end else if (sh[31:24] == smp_pkg::B1_WR_PG) begin
              st_d.fl_active = 1'b1;
              st_d.fl_idx    = '0;
              st_d.fl_page   = {sh[23:16], sh[15]};
              st_d.busy_page = {sh[23:16], sh[15]};
              st_d.busy_kind = BZ_FLASH;
              st_d.busy_cnt  = smp_pkg::BUSY_W'(FLASH_WAIT);
            end else if (sh[31:24] == smp_pkg::B1_WR_EE) begin
              // array erases the byte itself before writing it
              st_d.one_valid    = 1'b1;
              st_d.one_req.op   = smp_pkg::OP_EE_WR;
              st_d.one_req.hi   = 1'b0;
              st_d.one_req.addr = {4'h0, sh[19:8]};
              st_d.one_req.data = sh[7:0];
              st_d.busy_ee      = {4'h0, sh[19:8]};
              st_d.busy_kind    = BZ_EE;
              st_d.busy_cnt     = smp_pkg::BUSY_W'(EE_WAIT);
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // synchronisers reset to the idle pin levels; page buffer to erased
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      st_q       <= '0;
      st_q.rst_s <= 2'h3;
      st_q.pen_s <= 2'h3;
      st_q.pg    <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // write buffer
  // ----------------------------------------------------------------
  // a stalled array controller backs up into the page flush
  smp_fifo2 #(
    .W     ($bits(smp_pkg::smp_req_t)),
    .DEPTH (2)
  ) u_buf (
    .clk       (CLOCK),
    .rst_n     (RESETN),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (MEM_REQ_VALID),
    .out_ready (MEM_REQ_READY),
    .out_data  (MEM_REQ)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // data pin driven for the whole session, released otherwise
  assign ALT_DATA_OUT_PORT_BIT = st_q.out_sr[7];
  assign ALT_DATA_OUT_OE_N     = ~prog_mode;
  assign PROG_MODE             = prog_mode;
  assign PROG_ENABLED          = st_q.enabled;
  assign WRITE_BUSY            = busy_any;
  assign MEM_RD                = st_q.rd;

endmodule : smp_port

//--- sim/smp_mem_model.sv
// Purpose: array model behind the port's write buffer and read address
// Assumes: one request per valid/ready handshake, reads combinational
// Notes:   stall lets ready through one cycle in four
`timescale 1ns/1ps
module smp_mem_model (
  input  wire logic              clk,
  input  wire logic              stall,
  input  wire smp_pkg::smp_rd_t  rd,
  output logic [7:0]             rd_data,
  input  wire smp_pkg::smp_req_t req,
  input  wire logic              req_valid,
  output logic                   req_ready
);
  // ----------------
  // arrays
  // ----------------
  logic [7:0] fl [0:131071];
  logic [7:0] ee [0:4095];
  logic [1:0] cyc;
  // start non-erased, so a missed erase shows on read-back
  initial begin
    cyc = 2'h0;
    foreach (fl[i]) fl[i] = 8'h00;
    foreach (ee[i]) ee[i] = 8'h00;
  end
  // back-pressure pattern
  assign req_ready = !stall || (cyc == 2'h0);
  // addressed location on the read port; an assign follows array writes at once
  assign rd_data = (rd.space == smp_pkg::SP_EE) ? ee[rd.addr[11:0]]
                                                : fl[{rd.hi, rd.addr}];
  // take one request per handshake
  always @(posedge clk) begin
    cyc <= cyc + 2'h1;
    if (req_valid && req_ready) begin
      case (req.op)
        smp_pkg::OP_ERASE: begin
          foreach (fl[i]) fl[i] = smp_pkg::ERASED;
          foreach (ee[i]) ee[i] = smp_pkg::ERASED;
        end
        smp_pkg::OP_EE_WR: ee[req.addr[11:0]] <= req.data;
        default: fl[{req.hi, req.addr}] <= req.data;
      endcase
    end
  end
endmodule : smp_mem_model

//--- sim/smp_port_props.sv
// Purpose: port-level checks of the serial programming port
// Assumes: strap only lowered across a core reset, serial clock slow against CLOCK
// Notes:   bound to every smp_port instance
`timescale 1ns/1ps
module smp_port_props #(
  parameter int FLASH_WAIT = smp_pkg::FLASH_WAIT_CYC,
  parameter int EE_WAIT    = smp_pkg::EE_WAIT_CYC,
  parameter int ERASE_WAIT = smp_pkg::ERASE_WAIT_CYC
) (
  input wire logic              CLOCK,
  input wire logic              RESETN,
  input wire logic              RESET_PIN_N,
  input wire logic              PROG_ENABLE_PIN_N,
  input wire logic              SHARED_CLOCK_PORT_BIT,
  input wire logic              ALT_DATA_OUT_PORT_BIT,
  input wire logic              ALT_DATA_OUT_OE_N,
  input wire logic              PROG_MODE,
  input wire logic              PROG_ENABLED,
  input wire logic              WRITE_BUSY,
  input wire smp_pkg::smp_req_t MEM_REQ,
  input wire logic              MEM_REQ_VALID,
  input wire logic              MEM_REQ_READY
);
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  property p_oe_mode;
    !RESET_PIN_N [*3] |-> !ALT_DATA_OUT_OE_N && PROG_MODE;
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("data out enable not tied to mode");
  property p_mode_entry;
    $fell(RESET_PIN_N) |-> ##[1:3] PROG_MODE;
  endproperty
  a_mode_entry: assert property (p_mode_entry) else $error("mode not entered");
  property p_mode_exit;
    (RESET_PIN_N && PROG_ENABLE_PIN_N) [*4] |-> !PROG_MODE;
  endproperty
  a_mode_exit: assert property (p_mode_exit) else $error("mode kept after pin high");
  property p_enabled_clear;
    !PROG_MODE [*2] |-> !PROG_ENABLED;
  endproperty
  a_enabled_clear: assert property (p_enabled_clear) else $error("enable kept");
  property p_req_enabled;
    $rose(MEM_REQ_VALID) |-> PROG_ENABLED;
  endproperty
  a_req_enabled: assert property (p_req_enabled) else $error("write before enable");
  // a stalled request must not move or vanish
  property p_req_hold;
    MEM_REQ_VALID && !MEM_REQ_READY && PROG_MODE |=> MEM_REQ_VALID && $stable(MEM_REQ);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("stalled request changed");
  property p_busy_req;
    MEM_REQ_VALID |-> WRITE_BUSY;
  endproperty
  a_busy_req: assert property (p_busy_req) else $error("pending write not busy");
  property p_busy_min;
    $rose(WRITE_BUSY) |-> WRITE_BUSY [*8];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_out_fall;
    PROG_MODE && $past(PROG_MODE) && $changed(ALT_DATA_OUT_PORT_BIT)
      |-> !$past(SHARED_CLOCK_PORT_BIT, 2);
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("data out moved off falling edge");
  c_enable: cover property ($rose(PROG_ENABLED));
  c_stall: cover property (MEM_REQ_VALID && !MEM_REQ_READY);
  c_erase: cover property (MEM_REQ_VALID && MEM_REQ.op == smp_pkg::OP_ERASE);
endmodule : smp_port_props

bind smp_port smp_port_props #(
  .FLASH_WAIT(FLASH_WAIT),
  .EE_WAIT(EE_WAIT),
  .ERASE_WAIT(ERASE_WAIT)
) i_smp_port_props (.CLOCK, .RESETN, .RESET_PIN_N, .PROG_ENABLE_PIN_N,
  .SHARED_CLOCK_PORT_BIT, .ALT_DATA_OUT_PORT_BIT, .ALT_DATA_OUT_OE_N, .PROG_MODE,
  .PROG_ENABLED, .WRITE_BUSY, .MEM_REQ, .MEM_REQ_VALID, .MEM_REQ_READY);

//--- sim/smp_port_tb.sv
// Purpose: self-checking bench acting as the serial programmer
// Assumes: write timers shortened to WT cycles
// Notes:   serial clock 200 ns, still between frames
`timescale 1ns/1ps
module smp_port_tb;
  localparam int WT = 300;
  logic              clock, resetn, reset_pin_n, strap_n, sck, mosi, miso, oe_n;
  logic              prog_mode, prog_en, busy, req_valid, req_ready, stall;
  smp_pkg::smp_rd_t  mem_rd;
  smp_pkg::smp_req_t mem_req;
  logic [7:0]        rd_data, ed;
  logic [7:0]        pg [0:255];
  logic [31:0]       r;
  logic [15:0]       seed;
  logic [11:0]       ea;
  logic [8:0]        pgn;
  logic [6:0]        wd;
  int                failures, comparisons;

  smp_port #(.FLASH_WAIT(WT), .EE_WAIT(WT), .ERASE_WAIT(WT)) i_smp_port (
    .CLOCK(clock), .RESETN(resetn), .RESET_PIN_N(reset_pin_n),
    .PROG_ENABLE_PIN_N(strap_n), .SHARED_CLOCK_PORT_BIT(sck), .ALT_DATA_IN_PORT_BIT(mosi),
    .ALT_DATA_OUT_PORT_BIT(miso), .ALT_DATA_OUT_OE_N(oe_n), .PROG_MODE(prog_mode),
    .PROG_ENABLED(prog_en), .WRITE_BUSY(busy), .MEM_RD(mem_rd), .MEM_RD_DATA(rd_data),
    .MEM_REQ(mem_req), .MEM_REQ_VALID(req_valid), .MEM_REQ_READY(req_ready));
  smp_mem_model i_smp_mem_model (.clk(clock), .stall(stall), .rd(mem_rd), .rd_data(rd_data),
    .req(mem_req), .req_valid(req_valid), .req_ready(req_ready));

  // ----------------
  // helpers
  // ----------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkf(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask : chkf
  // one frame, msb first; data set while the clock is low
  task automatic xfer(input logic [31:0] f, output logic [31:0] q);
    for (int i = 31; i >= 0; i--) begin
      mosi = f[i];
      tick(4);
      q[i] = miso;
      sck = 1'b1;
      tick(4);
      sck = 1'b0;
    end
    tick(1);
    mosi = ~mosi; // idle line shows no stale bit
  endtask : xfer
  task automatic rdf(input logic [15:0] w, input logic h, input logic [7:0] exp);
    xfer({4'h2, h, 3'h0, w, 8'h00}, r);
    chk(r[7:0], exp);
  endtask : rdf
  task automatic rde(input logic [11:0] a, input logic [7:0] exp);
    xfer({8'ha0, 4'h5, a, 8'h00}, r);
    chk(r[7:0], exp);
  endtask : rde
  // bounded wait for the write machinery to go idle
  task automatic wait_idle;
    for (int n = 0; busy !== 1'b0; n++) begin
      if (n > 5000) begin
        failures++;
        $display("[ERR] %0t busy stuck", $time);
        complete_run;
      end
      tick(1);
    end
  endtask : wait_idle

  // ----------------
  // main sequence
  // ----------------
  initial begin
    {resetn, sck, mosi, stall, failures, comparisons} = '0;
    {reset_pin_n, strap_n} = 2'h3;
    seed = 16'ha7f0; // lfsr start 42992
    tick(8);
    resetn = 1'b1;
    tick(8);
    chkf(prog_mode, 1'b0);
    chkf(oe_n, 1'b1);
    reset_pin_n = 1'b0;
    tick(8);
    chkf(prog_mode, 1'b1);
    chkf(oe_n, 1'b0);
    xfer({8'hc0, 8'h00, 8'h10, 8'h5a}, r);
    tick(4);
    chkf(busy, 1'b0);
    tick(WT);
    xfer({8'hac, 8'h53, 8'h00, 8'h00}, r);
    chk(r[15:8], 8'h53);
    chk(r[31:24], 8'h00);
    tick(2);
    chkf(prog_en, 1'b1);
    xfer({8'hac, 8'h9f, 8'h00, 8'h00}, r);
    tick(4);
    chkf(busy, 1'b1);
    rde(12'h010, 8'hff);
    wait_idle;
    seed = lfsr(seed);
    rdf(seed, seed[0], 8'hff);
    ea = seed[11:0];
    for (int k = 0; k < 2; k++) begin
      stall = k[0];
      seed = lfsr(seed);
      ed = seed[7:0];
      xfer({8'hc0, 4'ha, ea, ed}, r);
      xfer({8'hc0, 4'h0, ~ea, 8'h12}, r);
      wait_idle;
    end
    rde(ea, ed);
    rde(~ea, 8'hff);
    stall = 1'b1;
    seed = lfsr(seed);
    pgn = seed[8:0];
    foreach (pg[i]) pg[i] = 8'hff;
    for (int w = 0; w < 8; w++) begin
      seed = lfsr(seed);
      wd = 7'(w / 2 * 37);
      pg[{wd, w[0]}] = seed[7:0];
      xfer({4'h4, w[0], 3'h0, 8'h00, 1'b0, wd, seed[7:0]}, r);
    end
    xfer({8'h4c, pgn[8:1], pgn[0], 7'h00, 8'h00}, r);
    rdf({pgn, 7'h00}, 1'b0, 8'hff);
    wait_idle;
    for (int w = 0; w < 8; w++) begin
      wd = 7'(w / 2 * 37);
      rdf({pgn, wd}, w[0], pg[{wd, w[0]}]);
    end
    rdf({pgn, 7'h7f}, 1'b1, 8'hff);
    reset_pin_n = 1'b1;
    tick(8);
    chkf(prog_mode, 1'b0);
    chkf(prog_en, 1'b0);
    chkf(oe_n, 1'b1);
    // core reset with the strap low: mode latched, kept across a pin pulse
    resetn = 1'b0;
    strap_n = 1'b0;
    tick(8);
    resetn = 1'b1;
    tick(8);
    chkf(prog_mode, 1'b1);
    chkf(prog_en, 1'b0);
    reset_pin_n = 1'b0;
    tick(8);
    reset_pin_n = 1'b1;
    tick(8);
    chkf(prog_mode, 1'b1);
    chkf(oe_n, 1'b0);
    xfer({8'hac, 8'h53, 8'h00, 8'h00}, r);
    chk(r[15:8], 8'h53);
    tick(2);
    chkf(prog_en, 1'b1);
    complete_run;
  end
endmodule : smp_port_tb
